// ### hmu_pkg.sv
// Package for the half-word multiply unit: opcodes, field positions, latency.
// Assumes one core clock; the decode stage and register file sit outside.
package hmu_pkg;
   localparam int WORD_W = 32;
   localparam int REG_W = 6;
   // Opcode field and immediate-form select bit
   localparam int OPC_LSB = 21;
   localparam int OPC_W = 5;
   localparam int IMM_SEL_BIT = 27;
   // Register-number fields
   localparam int FIRST_LSB = 0;
   localparam int SECOND_LSB = 6;
   localparam int DEST_REG_LSB = 12;
   localparam int DEST_IMM_LSB = 6;
   // Immediate field, bits 20..12
   localparam int IMM_LSB = 12;
   localparam int IMM_W = 9;
   localparam int LINK_REG = 63;
   // Bundles from issue to a readable result
   localparam int RESULT_LATENCY = 2;
   localparam logic [4:0] OPC_WORD_BY_LOW_SIGNED = 5'h15;
   localparam logic [4:0] OPC_LOW_BY_HIGH_SIGNED = 5'h1b;
   localparam logic [4:0] OPC_LOW_BY_HIGH_UNSIGNED = 5'h1c;
   localparam logic [4:0] OPC_WORD_BY_LOW_TOP = 5'h0f;
   localparam logic [4:0] OPC_LOW_BY_LOW_SIGNED = 5'h19;
   localparam logic [4:0] OPC_LOW_BY_LOW_UNSIGNED = 5'h1a;

   typedef struct packed {
      logic valid;
      logic [4:0] opcode;
      logic [REG_W-1:0] dest;
      logic [WORD_W-1:0] first_operand;
      logic [WORD_W-1:0] second_operand;
   } hmu_issue_s;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] dest;
      logic [WORD_W-1:0] data;
   } hmu_wb_s;
endpackage : hmu_pkg

// ### hmu_unit.sv
// Half-word multiply unit: decodes one instruction word, reads two register
// values from the decode stage, writes back after two cycles (one per bundle).
// Assumes the core issues one bundle per clock and honours placement limits.
`timescale 1ns/100ps

module hmu_unit
   import hmu_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Decode stage
   input wire logic issue_valid,
   input wire logic [31:0] instr_word,
   input wire logic [WORD_W-1:0] first_operand_register,
   input wire logic [WORD_W-1:0] second_operand_register,
   // Register file read addresses for the decode stage
   output logic [REG_W-1:0] first_read_index,
   output logic [REG_W-1:0] second_read_index,
   // Write-back
   output hmu_wb_s writeback
);

   hmu_issue_s next_stage1;
   hmu_issue_s stage1;
   logic [WORD_W-1:0] immediate_operand_field;
   logic opcode_known;

   // Sign- or zero-extended half-words and products, one function for all cases
   function automatic logic [WORD_W-1:0] mul_result(input logic [4:0] opc,
                                                     input logic [WORD_W-1:0] a,
                                                     input logic [WORD_W-1:0] b);
      logic signed [63:0] p;
      p = '0;
      unique case (opc)
         OPC_WORD_BY_LOW_SIGNED:
            p = 64'(signed'(a)) * 64'(signed'(b[15:0]));
         OPC_LOW_BY_HIGH_SIGNED:
            p = 64'(signed'(a[15:0])) * 64'(signed'(b[31:16]));
         OPC_LOW_BY_HIGH_UNSIGNED:
            p = signed'({48'h0, a[15:0]} * {48'h0, b[31:16]});
         OPC_WORD_BY_LOW_TOP:
            p = (64'(signed'(a)) * signed'({48'h0, b[15:0]})) >>> 32;
         OPC_LOW_BY_LOW_SIGNED:
            p = 64'(signed'(a[15:0])) * 64'(signed'(b[15:0]));
         OPC_LOW_BY_LOW_UNSIGNED:
            p = signed'({48'h0, a[15:0]} * {48'h0, b[15:0]});
         default:
            p = '0;
      endcase
      return p[WORD_W-1:0];
   endfunction : mul_result

   // Immediate sign-extended before any half-word extraction
   assign immediate_operand_field = WORD_W'(signed'(instr_word[IMM_LSB+IMM_W-1:IMM_LSB]));

   always_comb begin
      opcode_known = instr_word[OPC_LSB+OPC_W-1:OPC_LSB] inside {OPC_WORD_BY_LOW_SIGNED,
         OPC_LOW_BY_HIGH_SIGNED, OPC_LOW_BY_HIGH_UNSIGNED, OPC_WORD_BY_LOW_TOP,
         OPC_LOW_BY_LOW_SIGNED, OPC_LOW_BY_LOW_UNSIGNED};
      next_stage1.valid = issue_valid && opcode_known;
      next_stage1.opcode = instr_word[OPC_LSB+OPC_W-1:OPC_LSB];
      next_stage1.first_operand = first_operand_register;
      if (instr_word[IMM_SEL_BIT]) begin
         next_stage1.dest = instr_word[DEST_IMM_LSB+REG_W-1:DEST_IMM_LSB];
         next_stage1.second_operand = immediate_operand_field;
      end else begin
         next_stage1.dest = instr_word[DEST_REG_LSB+REG_W-1:DEST_REG_LSB];
         next_stage1.second_operand = second_operand_register;
      end
   end

   // Read indices registered so the decode stage sees them from a flip-flop
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         first_read_index <= '0;
         second_read_index <= '0;
      end else begin
         first_read_index <= instr_word[FIRST_LSB+REG_W-1:FIRST_LSB];
         second_read_index <= instr_word[SECOND_LSB+REG_W-1:SECOND_LSB];
      end
   end

   // Stage 1 captures operands; stage 2 holds the product: two-bundle latency
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= '0;
      end else begin
         stage1 <= next_stage1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         writeback <= '0;
      end else begin
         writeback.valid <= stage1.valid;
         writeback.dest <= stage1.dest;
         writeback.data <= mul_result(stage1.opcode, stage1.first_operand,
                                      stage1.second_operand);
      end
   end

   // Link register never targeted; no guard spent on it here
   AST_LATENCY_TWO: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && opcode_known) |-> ##2 writeback.valid)
      else $error("write-back missing two cycles after issue");
   AST_NO_SPURIOUS: assert property (@(posedge core_clk) disable iff (!resetn)
      !$past(next_stage1.valid, 2) |-> !writeback.valid)
      else $error("write-back without issue");
   AST_DEST_IMM: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && opcode_known && instr_word[IMM_SEL_BIT]) |->
      ##2 writeback.dest == $past(instr_word[DEST_IMM_LSB+REG_W-1:DEST_IMM_LSB], 2))
      else $error("immediate form destination wrong");
   AST_DEST_REG: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && opcode_known && !instr_word[IMM_SEL_BIT]) |->
      ##2 writeback.dest == $past(instr_word[DEST_REG_LSB+REG_W-1:DEST_REG_LSB], 2))
      else $error("register form destination wrong");
   AST_LL_UNSIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_LOW_UNSIGNED) |->
      ##2 writeback.data == $past(first_operand_register[15:0], 2) *
                            $past(second_operand_register[15:0], 2))
      else $error("unsigned low by low product wrong");
   AST_LH_UNSIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_HIGH_UNSIGNED) |->
      ##2 writeback.data == $past(first_operand_register[15:0], 2) *
                            $past(second_operand_register[31:16], 2))
      else $error("unsigned low by high product wrong");
   AST_TOP_SIGN: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_WORD_BY_LOW_TOP) |->
      ##2 (writeback.data[31:16] == {16{writeback.data[15]}}))
      else $error("top product bits not sign extended");
   AST_LL_SIGNED_SIGN: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_LOW_SIGNED &&
       first_operand_register[15:0] == 16'hffff) |->
      ##2 writeback.data == -$past(32'(signed'(second_operand_register[15:0])), 2))
      else $error("signed low by low product wrong");

   // Operand fetch indices trail the instruction by one cycle
   AST_FIRST_INDEX: assert property (@(posedge core_clk) disable iff (!resetn)
      issue_valid |=> first_read_index == $past(instr_word[FIRST_LSB+REG_W-1:FIRST_LSB]))
      else $error("first read index wrong");
   AST_SECOND_INDEX: assert property (@(posedge core_clk) disable iff (!resetn)
      issue_valid |=> second_read_index == $past(instr_word[SECOND_LSB+REG_W-1:SECOND_LSB]))
      else $error("second read index wrong");

   // Register form: only the low 32 product bits are compared
   AST_WORD_BY_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_WORD_BY_LOW_SIGNED) |->
      ##2 writeback.data == $past(first_operand_register, 2) *
         $past({{16{second_operand_register[15]}}, second_operand_register[15:0]}, 2))
      else $error("word by signed low product wrong");
   AST_LH_SIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_HIGH_SIGNED) |->
      ##2 writeback.data ==
         $past({{16{first_operand_register[15]}}, first_operand_register[15:0]}, 2) *
         $past({{16{second_operand_register[31]}}, second_operand_register[31:16]}, 2))
      else $error("signed low by high product wrong");
   AST_LL_SIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_LOW_SIGNED) |->
      ##2 writeback.data ==
         $past({{16{first_operand_register[15]}}, first_operand_register[15:0]}, 2) *
         $past({{16{second_operand_register[15]}}, second_operand_register[15:0]}, 2))
      else $error("signed low by low full product wrong");

   // Immediate form: the sign-extended field feeds every half-word pick
   AST_IMM_WORD_BY_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_WORD_BY_LOW_SIGNED) |->
      ##2 writeback.data == $past(first_operand_register, 2) *
         $past({{(WORD_W-IMM_W){instr_word[IMM_LSB+IMM_W-1]}},
                instr_word[IMM_LSB+IMM_W-1:IMM_LSB]}, 2))
      else $error("immediate word by low product wrong");
   AST_IMM_LH_SIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_HIGH_SIGNED) |->
      ##2 writeback.data ==
         $past({{16{first_operand_register[15]}}, first_operand_register[15:0]}, 2) *
         $past({WORD_W{instr_word[IMM_LSB+IMM_W-1]}}, 2))
      else $error("immediate signed low by high product wrong");
   AST_IMM_LH_UNSIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_HIGH_UNSIGNED) |->
      ##2 writeback.data == $past(first_operand_register[15:0], 2) *
         $past({16{instr_word[IMM_LSB+IMM_W-1]}}, 2))
      else $error("immediate unsigned low by high product wrong");
   AST_IMM_LL_SIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_LOW_SIGNED) |->
      ##2 writeback.data ==
         $past({{16{first_operand_register[15]}}, first_operand_register[15:0]}, 2) *
         $past({{(WORD_W-IMM_W){instr_word[IMM_LSB+IMM_W-1]}},
                instr_word[IMM_LSB+IMM_W-1:IMM_LSB]}, 2))
      else $error("immediate signed low by low product wrong");
   AST_IMM_LL_UNSIGNED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && instr_word[IMM_SEL_BIT] &&
       instr_word[OPC_LSB+OPC_W-1:OPC_LSB] == OPC_LOW_BY_LOW_UNSIGNED) |->
      ##2 writeback.data == $past(first_operand_register[15:0], 2) *
         $past({{(16-IMM_W){instr_word[IMM_LSB+IMM_W-1]}},
                instr_word[IMM_LSB+IMM_W-1:IMM_LSB]}, 2))
      else $error("immediate unsigned low by low product wrong");

   // Refused or idle cycles must leave the register file alone
   AST_UNKNOWN_DROPPED: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && !opcode_known) |-> ##2 !writeback.valid)
      else $error("write-back for an unknown opcode");
   AST_IDLE_DROPPED: assert property (@(posedge core_clk) disable iff (!resetn)
      !issue_valid |-> ##2 !writeback.valid)
      else $error("write-back for an idle cycle");
   AST_BACK_TO_BACK: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue_valid && opcode_known) ##1 (issue_valid && opcode_known) |->
      ##1 writeback.valid ##1 writeback.valid)
      else $error("back to back issues lost a write-back");
endmodule : hmu_unit

// ### hmu_core_model.sv
// Decode stage and register file model facing the multiply unit.
// Assumes one core clock; operands follow the instruction in the same cycle.
`timescale 1ns/100ps
module hmu_core_model
   import hmu_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Decode side
   input wire logic issue_valid,
   input wire logic [31:0] instr_word,
   output logic [WORD_W-1:0] first_operand_register,
   output logic [WORD_W-1:0] second_operand_register,
   // Write-back side
   input hmu_wb_s writeback
);
   logic [WORD_W-1:0] regs [64];
   initial for (int i = 0; i < 64; i++) regs[i] = 32'h9e37_79b9 * (i + 1);
   // Idle cycles show inverted values so a stale operand is never right
   assign first_operand_register = issue_valid ? regs[instr_word[5:0]] : ~regs[instr_word[5:0]];
   assign second_operand_register = issue_valid ? regs[instr_word[11:6]] : ~regs[instr_word[11:6]];
   always @(posedge core_clk) if (writeback.valid === 1'b1) regs[writeback.dest] <= writeback.data;
endmodule : hmu_core_model

// ### hmu_unit_test.sv
// Self-checking bench for the multiply unit against the core model.
// Assumes fixed two-cycle write-back; sources 1..4 and 40, results to 10 and up.
`timescale 1ns/100ps
module hmu_unit_test
   import hmu_pkg::*;
;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic issue_valid = 1'b0;
   logic [31:0] instr_word = 32'h0;
   logic [WORD_W-1:0] op_a, op_b;
   hmu_wb_s writeback;
   logic [REG_W-1:0] rd_first, rd_second;
   typedef struct {logic [5:0] d; logic [31:0] v; int at;} hmu_exp_s;
   hmu_exp_s expq[$];
   hmu_exp_s e;
   int cyc = 0;
   int n_errors = 0;
   int comparisons = 0;
   logic [4:0] ops [6] = '{OPC_WORD_BY_LOW_SIGNED, OPC_LOW_BY_HIGH_SIGNED,
      OPC_LOW_BY_HIGH_UNSIGNED, OPC_WORD_BY_LOW_TOP, OPC_LOW_BY_LOW_SIGNED, OPC_LOW_BY_LOW_UNSIGNED};
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   hmu_unit DUT (.core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid),
      .instr_word(instr_word), .first_operand_register(op_a), .second_operand_register(op_b),
      .first_read_index(rd_first), .second_read_index(rd_second), .writeback(writeback));
   hmu_core_model m (.core_clk(core_clk), .issue_valid(issue_valid), .instr_word(instr_word),
      .first_operand_register(op_a), .second_operand_register(op_b), .writeback(writeback));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   function automatic logic [31:0] expect_of(input logic [4:0] op, input logic [31:0] a, b);
      longint p;
      case (op)
         OPC_WORD_BY_LOW_SIGNED: p = longint'($signed(a)) * longint'($signed(b[15:0]));
         OPC_LOW_BY_HIGH_SIGNED: p = longint'($signed(a[15:0])) * longint'($signed(b[31:16]));
         OPC_LOW_BY_HIGH_UNSIGNED: p = longint'(a[15:0]) * longint'(b[31:16]);
         OPC_WORD_BY_LOW_TOP: p = (longint'($signed(a)) * longint'(b[15:0])) >>> 32;
         OPC_LOW_BY_LOW_SIGNED: p = longint'($signed(a[15:0])) * longint'($signed(b[15:0]));
         default: p = longint'(a[15:0]) * longint'(b[15:0]);
      endcase
      return p[31:0];
   endfunction : expect_of
   task automatic issue(input logic v, input logic [4:0] op, input logic im, input logic [8:0] k,
      input logic [5:0] s1, s2, d);
      logic [31:0] b;
      b = im ? {{23{k[8]}}, k} : m.regs[s2];
      @(posedge core_clk);
      issue_valid <= v;
      instr_word <= im ? {5'h1, 1'b0, op, k, d, s1} : {5'h0, 1'b0, op, 3'h0, d, s2, s1};
      if (v && op inside {ops}) expq.push_back('{d, expect_of(op, m.regs[s1], b), cyc + 3});
   endtask : issue
   task automatic drain;
      @(posedge core_clk);
      issue_valid <= 1'b0;
      repeat (8) @(posedge core_clk);
      if (expq.size() != 0) begin
         n_errors++;
         $display("MISMATCH pending writebacks expected 0 seen %0d", expq.size());
         test_done;
      end
   endtask : drain
   // Back to back, every opcode; results never aimed at the link register
   task automatic run_ops(input logic im);
      for (int i = 0; i < 6; i++) issue(1'b1, ops[i], im, i[0] ? 9'h1a5 : 9'h0b3, 6'(1 + i % 4),
         6'(1 + (i + 1) % 4), 6'(10 + i + 8 * im));
      drain;
   endtask : run_ops
   task automatic run_refused;
      issue(1'b0, OPC_LOW_BY_LOW_SIGNED, 1'b0, 9'h0, 6'd1, 6'd2, 6'd30);
      issue(1'b1, 5'h1d, 1'b0, 9'h0, 6'd3, 6'd4, 6'd31);
      issue(1'b1, 5'h00, 1'b1, 9'h1ff, 6'd2, 6'd0, 6'd32);
      issue(1'b1, OPC_LOW_BY_LOW_UNSIGNED, 1'b1, 9'h100, 6'd4, 6'd0, 6'd33);
      drain;
   endtask : run_refused
   // All-ones low half as first source wakes the signed low-by-low sign check
   task automatic run_corner;
      m.regs[40] = 32'h1234_ffff;
      issue(1'b1, OPC_LOW_BY_LOW_SIGNED, 1'b0, 9'h0, 6'h28, 6'h03, 6'h29);
      @(posedge core_clk);
      issue_valid <= 1'b0;
      @(negedge core_clk);
      check("first read index", 32'h28, {26'h0, rd_first});
      check("second read index", 32'h3, {26'h0, rd_second});
      drain;
   endtask : run_corner
   always @(negedge core_clk) begin
      if (resetn === 1'b1 && writeback.valid !== 1'b0) begin
         if (expq.size() != 0) e = expq.pop_front();
         else e = '{6'h0, 32'h0, -1};
         check("writeback cycle", 32'(e.at), 32'(cyc));
         check("writeback dest", {26'h0, e.d}, {26'h0, writeback.dest});
         check("writeback data", e.v, writeback.data);
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      check("writeback in reset", 32'h0, {25'h0, writeback.valid, writeback.dest});
      resetn <= 1'b1;
      run_ops(1'b0);
      run_ops(1'b1);
      run_refused;
      run_corner;
      test_done;
   end
endmodule : hmu_unit_test
